// ---- src/irendec_regs.svh ----
`ifndef IRENDEC_REGS_SVH
`define IRENDEC_REGS_SVH
`define IRENDEC_CNT_W 4
`define IRENDEC_DIV_W 16
`define IRENDEC_CNT_LAST 4'hF
`define IRENDEC_PULSE_FIRST 4'h7
`define IRENDEC_PULSE_LAST 4'h9
`define IRENDEC_UPDATE_CNT 4'h8
`define IRENDEC_WINDOW_CNT 4'hC
`endif

// ---- src/irendec_pkg.sv ----
`include "irendec_regs.svh"
package irendec_pkg;
	typedef enum logic {IRENDEC_IDLE, IRENDEC_RUN} irendec_state_type;
	// Encoder state: bit being sent and its tick position
	typedef struct packed {
		logic bit_val;
		logic [`IRENDEC_CNT_W-1:0] cnt;
	} irendec_enc_type;
	// Decoder state
	typedef struct packed {
		irendec_state_type state;
		logic [`IRENDEC_CNT_W-1:0] cnt;
		logic pend;
		logic win;
	} irendec_dec_type;
endpackage

// ---- src/irendec_baud_tick.sv ----
`timescale 1ns/1ps
`include "irendec_regs.svh"
module irendec_baud_tick #(
	parameter int DIV_W = `IRENDEC_DIV_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [DIV_W/2-1:0] div_high,
	input wire logic [DIV_W/2-1:0] div_low,
	output logic tick
);
	logic [DIV_W-1:0] div_cnt_reg;
	logic [DIV_W-1:0] div_cnt_next;
	logic tick_reg;
	logic tick_next;
	logic [DIV_W-1:0] divisor;

	// Divisor of zero wraps and gives the longest period
	assign divisor = {div_high, div_low};
	// At or above the end count, so a divisor lowered below the running
	// count ticks at once instead of waiting for a full wrap
	always_comb begin
		tick_next = (div_cnt_reg >= DIV_W'(divisor - 1'b1));
		div_cnt_next = tick_next ? '0 : DIV_W'(div_cnt_reg + 1'b1);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// ---- src/irendec_top.sv ----
`timescale 1ns/1ps
`include "irendec_regs.svh"
module irendec_top
	import irendec_pkg::*;
#(
	parameter int DIV_W = `IRENDEC_DIV_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic infrared_enable_bit,
	input wire logic [DIV_W/2-1:0] baud_div_high,
	input wire logic [DIV_W/2-1:0] baud_div_low,
	input wire logic uart_txd,
	input wire logic uart_tx_busy,
	output logic uart_rxd,
	output logic txd_pin_out,
	input wire logic rxd_pin_in,
	output logic baud_tick
);
	localparam logic [`IRENDEC_CNT_W-1:0] CNT_ONE = 4'h1;
	logic tick;
	irendec_enc_type enc_reg;
	irendec_enc_type enc_next;
	irendec_dec_type dec_reg;
	irendec_dec_type dec_next;
	logic rx_s1_reg;
	logic rx_s2_reg;
	logic rx_s3_reg;
	logic rx_fall;
	logic ir_mod;
	logic txd_pin_reg;
	logic txd_pin_next;
	logic rxd_out_reg;
	logic rxd_out_next;
	logic rx_allowed;

	// One baud tick per divisor count; 16 ticks make one bit
	irendec_baud_tick #(.DIV_W(DIV_W)) u_tick (
		.mclk(mclk),
		.rst_n(rst_n),
		.div_high(baud_div_high),
		.div_low(baud_div_low),
		.tick(tick)
	);
	assign baud_tick = tick;

	// Encoder: restart the symbol whenever the UART line changes level.
	// The UART only changes its line on bit edges, so this aligns the
	// 16-tick symbol without needing the UART's internal phase.
	always_comb begin
		enc_next = enc_reg;
		if (tick) begin
			if (uart_txd != enc_reg.bit_val) begin
				enc_next.bit_val = uart_txd;
				enc_next.cnt = '0;
			end else begin
				enc_next.cnt = enc_reg.cnt + CNT_ONE;
			end
		end
	end

	// High only for ticks 7..9 of a zero bit; a one stays low
	assign ir_mod = !enc_reg.bit_val &&
		enc_reg.cnt >= `IRENDEC_PULSE_FIRST &&
		enc_reg.cnt <= `IRENDEC_PULSE_LAST;

	// Pin drive selects modulated or plain UART data
	always_comb begin
		txd_pin_next = infrared_enable_bit ? ir_mod : uart_txd;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			enc_reg <= '{bit_val: 1'b1, cnt: '0};
			txd_pin_reg <= 1'b0;
		end else begin
			enc_reg <= enc_next;
			txd_pin_reg <= txd_pin_next;
		end
	end
	assign txd_pin_out = txd_pin_reg;

	// Pin synchroniser; the edge detector looks only at stages two and three
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_s3_reg <= 1'b1;
		end else begin
			rx_s1_reg <= rxd_pin_in;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
		end
	end
	assign rx_fall = rx_s3_reg && !rx_s2_reg;

	// Our own transmit echo must not be decoded
	assign rx_allowed = infrared_enable_bit && !uart_tx_busy;

	// Decoder: pend holds the bit to hand over at count 8, assumed one
	// until a pulse is seen, so a silent window yields a one.
	always_comb begin
		dec_next = dec_reg;
		if (!rx_allowed) begin
			dec_next = '{state: IRENDEC_IDLE, cnt: '0, pend: 1'b1, win: 1'b0};
		end else if (rx_fall) begin
			dec_next.state = IRENDEC_RUN;
			dec_next.cnt = '0;
			dec_next.pend = 1'b0;
			dec_next.win = 1'b0;
		end else if (tick) begin
			case (dec_reg.state)
				IRENDEC_IDLE: begin
					dec_next.cnt = '0;
				end
				IRENDEC_RUN: begin
					dec_next.cnt = dec_reg.cnt + CNT_ONE;
					if (dec_next.cnt == `IRENDEC_WINDOW_CNT) begin
						dec_next.win = 1'b1;
					end
					// A second count of 8 with no pulse closes the window
					if (dec_next.cnt == `IRENDEC_UPDATE_CNT) begin
						dec_next.pend = 1'b1;
						if (dec_reg.pend) begin
							dec_next.state = IRENDEC_IDLE;
							dec_next.win = 1'b0;
							dec_next.cnt = '0;
						end
					end
				end
				default: begin
					dec_next.state = IRENDEC_IDLE;
				end
			endcase
		end
	end

	// While decoding is allowed, the UART receive line moves only at count 8; it never sees the resets
	always_comb begin
		rxd_out_next = rxd_out_reg;
		if (!infrared_enable_bit) begin
			rxd_out_next = rx_s2_reg;
		end else if (!rx_allowed) begin
			rxd_out_next = 1'b1;
		end else if (tick && dec_reg.state == IRENDEC_RUN &&
			dec_reg.cnt == `IRENDEC_UPDATE_CNT - CNT_ONE) begin
			rxd_out_next = dec_reg.pend;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dec_reg <= '{state: IRENDEC_IDLE, cnt: '0, pend: 1'b1, win: 1'b0};
			rxd_out_reg <= 1'b1;
		end else begin
			dec_reg <= dec_next;
			rxd_out_reg <= rxd_out_next;
		end
	end
	assign uart_rxd = rxd_out_reg;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_one_low: assert property (
		$past(infrared_enable_bit) && $past(enc_reg.bit_val) |-> !txd_pin_out)
		else $error("one bit produced a pulse");
	chk_zero_pulse: assert property (
		$past(infrared_enable_bit) && !$past(enc_reg.bit_val) &&
		$past(enc_reg.cnt) == 4'h8 |-> txd_pin_out)
		else $error("zero bit missing pulse at tick 8");
	chk_zero_low: assert property (
		$past(infrared_enable_bit) && !$past(enc_reg.bit_val) &&
		($past(enc_reg.cnt) == 4'h6 || $past(enc_reg.cnt) == 4'hA)
		|-> !txd_pin_out)
		else $error("zero bit pulse too wide");
	chk_bit_period: assert property (
		tick && enc_reg.cnt == `IRENDEC_CNT_LAST &&
		uart_txd == enc_reg.bit_val |=> enc_reg.cnt == '0)
		else $error("symbol not 16 ticks");
	// The first edge after reset still shows the reset value of the pin
	chk_pass_through: assert property (
		$past(rst_n) && !$past(infrared_enable_bit) |->
		txd_pin_out == $past(uart_txd) &&
		uart_rxd == $past(rx_s2_reg))
		else $error("disabled path not transparent");
	chk_cnt_reset: assert property (
		rx_allowed && rx_fall |=> dec_reg.cnt == '0 &&
		dec_reg.state == IRENDEC_RUN)
		else $error("falling edge did not clear counter");
	chk_rx_update: assert property (
		rx_allowed && tick && dec_reg.state == IRENDEC_RUN &&
		dec_reg.cnt == 4'h7 |=> uart_rxd == $past(dec_reg.pend))
		else $error("receive line not updated at count 8");
	chk_window_open: assert property (
		rx_allowed && !rx_fall && tick && dec_reg.state == IRENDEC_RUN &&
		dec_reg.cnt == 4'hB |=> dec_reg.win)
		else $error("window not open at count 12");
	chk_no_pulse_idle: assert property (
		rx_allowed && !rx_fall && tick && dec_reg.state == IRENDEC_RUN &&
		dec_reg.cnt == 4'h7 && dec_reg.pend |=>
		dec_reg.state == IRENDEC_IDLE && uart_rxd)
		else $error("empty window did not idle as one");
	chk_half_duplex: assert property (
		uart_tx_busy |=> dec_reg.state == IRENDEC_IDLE)
		else $error("decoder active during transmit");
	chk_window_close: assert property (
		rx_allowed && !rx_fall && tick && dec_reg.state == IRENDEC_RUN &&
		dec_reg.cnt == 4'h7 |=> !dec_reg.win)
		else $error("window still open at count 8");
	// Resync edges must never reach the UART line between updates
	chk_rx_hold: assert property (
		$past(rx_allowed) && $changed(uart_rxd) |->
		$past(tick) && $past(dec_reg.cnt) == 4'h7 &&
		$past(dec_reg.state) == IRENDEC_RUN)
		else $error("receive line moved outside count 8");
	chk_symbol_restart: assert property (
		tick && uart_txd != enc_reg.bit_val |=> enc_reg.cnt == '0 &&
		enc_reg.bit_val == $past(uart_txd))
		else $error("new bit did not restart the symbol");

	cov_zero_sent: cover property ($rose(txd_pin_out) && infrared_enable_bit);
	cov_pulse_in_window: cover property (dec_reg.win && rx_fall);
	cov_decoded_zero: cover property (infrared_enable_bit && $fell(uart_rxd));
	cov_return_idle: cover property (
		dec_reg.state == IRENDEC_RUN ##1 dec_reg.state == IRENDEC_IDLE);
	cov_blind_busy: cover property (uart_tx_busy && rx_fall);
endmodule

// ---- testbench/irendec_xcvr.sv ----
`timescale 1ns/1ps
module irendec_xcvr (
	input wire logic mclk,
	input wire logic ir_light,
	input wire logic flash_req,
	input wire logic [15:0] flash_len,
	output logic ir_rx_n
);
	logic [15:0] left_reg = 16'h0000;
	// A flash is refused while our own emitter is lit, as on one optical path
	always_ff @(posedge mclk) begin
		if (flash_req && !ir_light) begin
			left_reg <= flash_len;
		end else if (left_reg != 16'h0000) begin
			left_reg <= left_reg - 16'h0001;
		end
	end
	// Pulled-up detector output: low only while light is seen
	assign ir_rx_n = (left_reg == 16'h0000);
endmodule

// ---- testbench/tb_irendec_top.sv ----
`timescale 1ns/1ps
module tb_irendec_top;
	import irendec_pkg::*;
	localparam int DIV = 3;
	logic mclk = 0, rst_n = 0, en = 0, txd = 1, busy = 0, req = 0;
	logic rxd, pin_out, pin_in, tick;
	logic [7:0] div_hi = 8'h00, div_lo = 8'h03;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	irendec_top u_dut (.mclk(mclk), .rst_n(rst_n), .infrared_enable_bit(en),
		.baud_div_high(div_hi), .baud_div_low(div_lo), .uart_txd(txd),
		.uart_tx_busy(busy), .uart_rxd(rxd), .txd_pin_out(pin_out),
		.rxd_pin_in(pin_in), .baud_tick(tick));
	irendec_xcvr u_xcvr (.mclk(mclk), .ir_light(pin_out), .flash_req(req),
		.flash_len(16'h0006), .ir_rx_n(pin_in));
	// Free-running system clock
	initial begin
		forever #20 mclk = ~mclk;
	end
	// Hang guard, well above the fewer than two thousand cycles the run needs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: %s got %0d want %0d", $time, what, seen, exp);
		end
	endtask
	// One light flash from the far transceiver
	task automatic send();
		req = 1;
		@(negedge mclk);
		req = 0;
	endtask
	task automatic wait_rxd(input logic v, output int n);
		n = 0;
		while (rxd !== v && n < 40 * DIV) begin
			@(negedge mclk);
			n++;
		end
	endtask
	// Counts high cycles and rising edges of the pin over n cycles
	task automatic watch(input int n, output int hi, rises, r0, r1);
		logic last;
		hi = 0;
		rises = 0;
		r0 = 0;
		r1 = 0;
		last = pin_out;
		for (int i = 1; i <= n; i++) begin
			@(negedge mclk);
			hi += (pin_out === 1'b1);
			if (pin_out === 1'b1 && last === 1'b0) begin
				rises++;
				r0 = (rises == 1) ? i : r0;
				r1 = (rises == 2) ? i : r1;
			end
			last = pin_out;
		end
	endtask
	task automatic t_tick();
		int n = 0;
		repeat (30 * DIV) begin
			@(negedge mclk);
			n += (tick === 1'b1);
		end
		check(n, 30, "tick count");
		// Divisor of 256 lives in the high byte only, so byte order shows
		div_hi = 8'h01;
		div_lo = 8'h00;
		repeat (300) @(negedge mclk);
		n = 0;
		repeat (512) begin
			@(negedge mclk);
			n += (tick === 1'b1);
		end
		check(n, 2, "divisor byte order");
		div_hi = 8'h00;
		div_lo = 8'h03;
		repeat (4) @(negedge mclk);
	endtask
	task automatic t_pass();
		txd = 0;
		repeat (2) @(negedge mclk);
		check(pin_out, 0, "pass tx low");
		// Flash while the pin is dark, else the far side refuses it
		send();
		repeat (4) @(negedge mclk);
		check(rxd, 0, "pass rx");
		txd = 1;
		repeat (2) @(negedge mclk);
		check(pin_out, 1, "pass tx high");
		repeat (10) @(negedge mclk);
	endtask
	task automatic t_enc();
		int hi, rises, r0, r1;
		en = 1;
		repeat (40 * DIV) @(negedge mclk);
		txd = 0;
		watch(64 * DIV, hi, rises, r0, r1);
		check(hi, 12 * DIV, "zero pulse width");
		check(rises, 4, "pulses per four zeros");
		check(r1 - r0, 16 * DIV, "symbol period");
		check(r0 >= 7*DIV+1 && r0 <= 8*DIV+2, 1, "pulse position");
		txd = 1;
		watch(32 * DIV, hi, rises, r0, r1);
		check(hi, 0, "one stays dark");
	endtask
	task automatic t_dec();
		int d, n;
		send();
		wait_rxd(0, d);
		check(d >= 7*DIV && d <= 8*DIV+4, 1, "decode delay");
		wait_rxd(1, n);
		check(n, 16 * DIV, "lone zero length");
		repeat (30 * DIV) @(negedge mclk);
		// Second flash lands inside the window and must resync the count
		send();
		wait_rxd(0, d);
		repeat (20 * DIV - 1 - d) @(negedge mclk);
		send();
		wait_rxd(1, n);
		check(20 * DIV + n - d, 36 * DIV, "two zero length");
		busy = 1;
		send();
		wait_rxd(0, d);
		check(rxd, 1, "blind while sending");
		busy = 0;
	endtask
	// Main sequence; inputs move on falling edges only
	initial begin
		repeat (8) @(negedge mclk);
		check(rxd, 1, "reset rx idle");
		check(pin_out, 0, "reset tx dark");
		rst_n = 1;
		t_tick();
		t_pass();
		t_enc();
		t_dec();
		results();
	end
endmodule
